// File: pwg_counter.sv
// One period counter with its clock source select and prescaler.
// Assumes slow and fast ticks are one-cycle enables synchronous to aclk.
`timescale 1ns/1ps
`include "pwg_params.svh"

module pwg_counter (
	// Clock and reset.
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// Clock source ticks.
	input  wire logic                  slow_tick,
	input  wire logic                  fast_tick,
	// Settings.
	input  wire logic                  clk_sel,
	input  wire pwg_pkg::pwg_psc_type  psc,
	input  wire pwg_pkg::pwg_byte_type period,
	input  wire logic                  hold,
	// Counter state.
	output logic [7:0]                 count_ff,
	output logic                       wrap_ff
);

	logic [6:0] pre_ff;
	logic [6:0] term;
	logic       src_tick;
	logic       cnt_tick;

	////////////////////////////////////////////////////////////////////
	// Code 000 divides by 128 and each step halves it down to one.
	assign src_tick = clk_sel ? fast_tick : slow_tick;
	assign term     = `PWG_PSC_TERM_MAX >> psc;
	// Greater-or-equal lets a smaller divisor take effect at once; an
	// equality test would stall until the prescaler rolled over.
	assign cnt_tick = src_tick && (pre_ff >= term);

	// Prescaler; the hold restarts it so the first period is whole.
	always_ff @(posedge aclk) begin
		if (!aresetn || hold) begin
			pre_ff <= 7'h00;
		end else if (cnt_tick) begin
			pre_ff <= 7'h00;
		end else if (src_tick) begin
			pre_ff <= pre_ff + 7'h01;
		end
	end

	// A value N gives N+1 count clocks per period.
	always_ff @(posedge aclk) begin
		if (!aresetn || hold) begin
			count_ff <= 8'h00;
			wrap_ff  <= 1'b0;
		end else if (cnt_tick && (count_ff >= period)) begin
			count_ff <= 8'h00;
			wrap_ff  <= 1'b1;
		end else begin
			count_ff <= cnt_tick ? count_ff + 8'h01 : count_ff;
			wrap_ff  <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	a_hold_clears: assert property (@(posedge aclk) disable iff (!aresetn)
		hold |=> (count_ff == 8'h00) && !wrap_ff)
		else $error("Counter not cleared while held.");

	a_wrap_restart: assert property (@(posedge aclk) disable iff (!aresetn)
		wrap_ff |-> (count_ff == 8'h00) && ($past(count_ff) >= $past(period)))
		else $error("Wrap without reaching the period value.");

	a_count_steps: assert property (@(posedge aclk) disable iff (!aresetn)
		(!cnt_tick && !hold) |=> $stable(count_ff))
		else $error("Counter moved without a count clock.");

endmodule : pwg_counter

// File: pwg_params.svh
// Constants for the six-channel waveform generator: register indexes,
// reset values, field positions and bus codes.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef PWG_PARAMS_SVH
`define PWG_PARAMS_SVH

// Register indexes; the byte address is four times the index.
`define PWG_IDX_INT_FLAGS   10'h095
`define PWG_IDX_CH0_PERIOD  10'h09a
`define PWG_IDX_CH0_DUTY    10'h09b
`define PWG_IDX_CH14_PERIOD 10'h09c
`define PWG_IDX_CH1_DUTY    10'h09d
`define PWG_IDX_CH2_DUTY    10'h09e
`define PWG_IDX_CH3_DUTY    10'h09f
`define PWG_IDX_CLK_CTRL    10'h0ce
`define PWG_IDX_CLK_CTRL5   10'h0cf
`define PWG_IDX_CH4_DUTY    10'h0d4
`define PWG_IDX_CH5_DUTY    10'h0d5
`define PWG_IDX_CH5_PERIOD  10'h0d6
`define PWG_IDX_PIN_ENABLES 10'h0d7

// Reset values.
`define PWG_RST_PERIOD      8'hff
`define PWG_RST_DUTY        8'h80
`define PWG_RST_CLK_CTRL    8'h00
`define PWG_RST_CLK_CTRL5   7'h40
`define PWG_RST_PIN_EN      8'h00

// Field positions.
`define PWG_CH14_CKS_BIT    7
`define PWG_CH14_PSC_HI     6
`define PWG_CH14_PSC_LO     4
`define PWG_CH0_CKS_BIT     3
`define PWG_PSC_HI          2
`define PWG_PSC_LO          0
`define PWG_CH5_CLR_BIT     6
`define PWG_PUMP_BIT        5
`define PWG_SINK_BIT        4
`define PWG_CH5_CKS_BIT     3
`define PWG_FLAG_BIT        3

// Prescaler terminal for code 000 (divide by 128).
`define PWG_PSC_TERM_MAX    7'h7f

// AXI responses.
`define PWG_RESP_OKAY       2'h0
`define PWG_RESP_SLVERR     2'h2

`endif

// File: pwg_pin_load.sv
// Load model for the eight waveform pins: LEDs or emitters to ground.
// Assumes pins are sampled on aclk and the bench frames each measurement.
`timescale 1ns/1ps

module pwg_pin_load (
	// Clock.
	input  wire logic            aclk,
	// Pin drive from the generator.
	input  wire logic [7:0]      pin_out,
	input  wire logic [7:0]      pin_oe_n,
	// Measurement control from the bench.
	input  wire logic            clr,
	input  wire logic            meas,
	// Lit-cycle counts, one byte for each pin.
	output logic [7:0][7:0]      hi_cnt
);
	logic [7:0] level;

	////////////////////////////////////////////////////////////////////////
	// A released pin is pulled down by the load, so only a driven high lights.
	assign level = pin_out & ~pin_oe_n;

	// Counts lit cycles; the window must span whole periods to be exact.
	always_ff @(posedge aclk) begin
		for (int i = 0; i < 8; i++) begin
			if (clr) begin
				hi_cnt[i] <= 8'h00;
			end else if (meas && level[i]) begin
				hi_cnt[i] <= hi_cnt[i] + 8'h01;
			end
		end
	end
endmodule : pwg_pin_load

// File: pwg_pkg.sv
// Types shared by the waveform generator modules.
// Assumes nothing of its surroundings.
package pwg_pkg;
	typedef logic [7:0] pwg_byte_type;
	typedef logic [2:0] pwg_psc_type;
endpackage : pwg_pkg

// File: pwg_top.sv
// Six-channel 8-bit waveform generator with an AXI4-Lite register slave.
// Assumes slow and fast clock ticks are one-cycle enables on aclk and
// that isr_entry pulses when the processor enters the channel-5 handler.
//
// Operation
// - Six channels, slow/fast source, divide 1..128.
// - 8-bit period and 8-bit duty registers.
// - Channel 0 drives positive and negative pair.
// - Channel 5 interrupts and wakes the processor.
// - Shared channel 1-4 source: 0 slow, 1 fast.
// - Prescaler code 000 divides 128, 111 by one.
// - Channel 0 own source bit and prescaler.
// - Channel 5 own source bit and prescaler.
// - Channels 1-4 share period, separate duties.
// - Period value N lasts N+1 count clocks.
// - Duty value N is active N clocks.
// - Each enable bit routes one waveform to pin.
// - Period-full flag set; handler entry or write clears.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "pwg_params.svh"

module pwg_top (
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Write address channel.
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// Write data channel.
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// Write response channel.
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// Read address channel.
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// Read data channel.
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Clock source ticks.
	input  wire logic        slow_tick,
	input  wire logic        fast_tick,
	// Processor side of the channel-5 event.
	input  wire logic        isr_entry,
	output logic             ch5_irq,
	output logic             ch5_wake,
	// Pin drive controls.
	output logic             ch0_pump_drive_select,
	output logic             ch1_high_sink_select,
	// Pins: 7 ch5, 6 ch4 B, 5 ch4 A, 4 ch3, 3 ch2, 2 ch1, 1 ch0 pos,
	// 0 ch0 neg.
	output logic [7:0]       pwm_pin_out,
	output logic [7:0]       pwm_pin_oe_n
);

	// Register state.
	pwg_pkg::pwg_byte_type ch0_period_ff;
	pwg_pkg::pwg_byte_type ch1_to_4_period_ff;
	pwg_pkg::pwg_byte_type ch5_period_ff;
	pwg_pkg::pwg_byte_type duty_ff [0:5];
	pwg_pkg::pwg_byte_type clock_control_ff;
	logic [6:0]            clock_control5_ff;
	pwg_pkg::pwg_byte_type pin_enables_ff;
	logic                  ch5_period_full_flag_ff;

	// Bus state.
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        rvalid_ff;
	logic [1:0]  rresp_ff;
	logic [31:0] rdata_ff;
	logic        wr_take;
	logic        rd_take;
	logic [9:0]  wr_idx;
	logic [9:0]  rd_idx;
	logic        wr_hit;
	logic        rd_hit;
	logic [7:0]  wbyte;
	logic        wlane;
	logic [7:0]  nxt_rbyte;

	// Channel state.
	logic [7:0]  cnt0;
	logic [7:0]  cnt14;
	logic [7:0]  cnt5;
	logic        wrap5;
	logic [5:0]  wave_ff;
	logic [7:0]  pin_ff;
	logic [7:0]  wave_pins;
	logic        ch5_hold;

	////////////////////////////////////////////////////////////////////
	// Write path. Address and data are taken together in one edge; the
	// slave waits for both rather than buffering one, which costs nothing
	// since the master offers them at once.
	assign wr_take       = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
	assign s_axi_awready = wr_take;
	assign s_axi_wready  = wr_take;
	assign wr_idx        = s_axi_awaddr[11:2];
	assign wbyte         = s_axi_wdata[7:0];
	assign wlane         = s_axi_wstrb[0];

	// Which indexes hold a register.
	function automatic logic idx_mapped(input logic [9:0] idx);
		idx_mapped = (idx == `PWG_IDX_INT_FLAGS)   ||
			(idx == `PWG_IDX_CH0_PERIOD)  || (idx == `PWG_IDX_CH0_DUTY)  ||
			(idx == `PWG_IDX_CH14_PERIOD) || (idx == `PWG_IDX_CH1_DUTY)  ||
			(idx == `PWG_IDX_CH2_DUTY)    || (idx == `PWG_IDX_CH3_DUTY)  ||
			(idx == `PWG_IDX_CLK_CTRL)    || (idx == `PWG_IDX_CLK_CTRL5) ||
			(idx == `PWG_IDX_CH4_DUTY)    || (idx == `PWG_IDX_CH5_DUTY)  ||
			(idx == `PWG_IDX_CH5_PERIOD)  || (idx == `PWG_IDX_PIN_ENABLES);
	endfunction : idx_mapped

	assign wr_hit = idx_mapped(wr_idx);
	assign rd_hit = idx_mapped(rd_idx);

	// Write response, one cycle after the take, held until bready.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= `PWG_RESP_OKAY;
		end else if (wr_take) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= wr_hit ? `PWG_RESP_OKAY : `PWG_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp  = bresp_ff;

	////////////////////////////////////////////////////////////////////
	// Configuration registers; only byte lane 0 carries data.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ch0_period_ff      <= `PWG_RST_PERIOD;
			ch1_to_4_period_ff <= `PWG_RST_PERIOD;
			ch5_period_ff      <= `PWG_RST_PERIOD;
			clock_control_ff   <= `PWG_RST_CLK_CTRL;
			clock_control5_ff  <= `PWG_RST_CLK_CTRL5;
			pin_enables_ff     <= `PWG_RST_PIN_EN;
		end else if (wr_take && wlane) begin
			if (wr_idx == `PWG_IDX_CH0_PERIOD) begin
				ch0_period_ff <= wbyte;
			end else if (wr_idx == `PWG_IDX_CH14_PERIOD) begin
				ch1_to_4_period_ff <= wbyte;
			end else if (wr_idx == `PWG_IDX_CH5_PERIOD) begin
				ch5_period_ff <= wbyte;
			end else if (wr_idx == `PWG_IDX_CLK_CTRL) begin
				clock_control_ff <= wbyte;
			end else if (wr_idx == `PWG_IDX_CLK_CTRL5) begin
				clock_control5_ff <= wbyte[6:0];
			end else if (wr_idx == `PWG_IDX_PIN_ENABLES) begin
				pin_enables_ff <= wbyte;
			end
		end
	end

	// Duty registers, one per channel.
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi = gi + 1) begin : g_duty
			logic [9:0] duty_idx;
			assign duty_idx = (gi == 0) ? `PWG_IDX_CH0_DUTY :
				(gi == 1) ? `PWG_IDX_CH1_DUTY :
				(gi == 2) ? `PWG_IDX_CH2_DUTY :
				(gi == 3) ? `PWG_IDX_CH3_DUTY :
				(gi == 4) ? `PWG_IDX_CH4_DUTY : `PWG_IDX_CH5_DUTY;
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					duty_ff[gi] <= `PWG_RST_DUTY;
				end else if (wr_take && wlane && (wr_idx == duty_idx)) begin
					duty_ff[gi] <= wbyte;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Period-full flag. Writing the flags register with its bit at zero
	// clears it, so F7h clears only this flag; a wrap in the same cycle
	// as either clear still sets it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ch5_period_full_flag_ff <= 1'b0;
		end else if (wrap5) begin
			ch5_period_full_flag_ff <= 1'b1;
		end else if (isr_entry) begin
			ch5_period_full_flag_ff <= 1'b0;
		end else if (wr_take && wlane && (wr_idx == `PWG_IDX_INT_FLAGS) &&
			!wbyte[`PWG_FLAG_BIT]) begin
			ch5_period_full_flag_ff <= 1'b0;
		end
	end

	// The flag raises the request and wakes the processor from idle.
	assign ch5_irq  = ch5_period_full_flag_ff;
	assign ch5_wake = ch5_period_full_flag_ff;

	////////////////////////////////////////////////////////////////////
	// Read path; unmapped addresses read zero with SLVERR.
	assign rd_take       = s_axi_arvalid && !rvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign rd_idx        = s_axi_araddr[11:2];

	always_comb begin
		nxt_rbyte = 8'h00;
		if (rd_idx == `PWG_IDX_INT_FLAGS) begin
			nxt_rbyte[`PWG_FLAG_BIT] = ch5_period_full_flag_ff;
		end else if (rd_idx == `PWG_IDX_CH0_PERIOD) begin
			nxt_rbyte = ch0_period_ff;
		end else if (rd_idx == `PWG_IDX_CH0_DUTY) begin
			nxt_rbyte = duty_ff[0];
		end else if (rd_idx == `PWG_IDX_CH14_PERIOD) begin
			nxt_rbyte = ch1_to_4_period_ff;
		end else if (rd_idx == `PWG_IDX_CH1_DUTY) begin
			nxt_rbyte = duty_ff[1];
		end else if (rd_idx == `PWG_IDX_CH2_DUTY) begin
			nxt_rbyte = duty_ff[2];
		end else if (rd_idx == `PWG_IDX_CH3_DUTY) begin
			nxt_rbyte = duty_ff[3];
		end else if (rd_idx == `PWG_IDX_CLK_CTRL) begin
			nxt_rbyte = clock_control_ff;
		end else if (rd_idx == `PWG_IDX_CLK_CTRL5) begin
			nxt_rbyte = {1'b0, clock_control5_ff};
		end else if (rd_idx == `PWG_IDX_CH4_DUTY) begin
			nxt_rbyte = duty_ff[4];
		end else if (rd_idx == `PWG_IDX_CH5_DUTY) begin
			nxt_rbyte = duty_ff[5];
		end else if (rd_idx == `PWG_IDX_CH5_PERIOD) begin
			nxt_rbyte = ch5_period_ff;
		end else if (rd_idx == `PWG_IDX_PIN_ENABLES) begin
			nxt_rbyte = pin_enables_ff;
		end
	end

	// Read answer, one cycle after the take, held until rready.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rresp_ff  <= `PWG_RESP_OKAY;
			rdata_ff  <= 32'h0000_0000;
		end else if (rd_take) begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= rd_hit ? `PWG_RESP_OKAY : `PWG_RESP_SLVERR;
			rdata_ff  <= {24'h00_0000, nxt_rbyte};
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp  = rresp_ff;
	assign s_axi_rdata  = rdata_ff;

	////////////////////////////////////////////////////////////////////
	// Three counter groups: channel 0, the shared 1-4 group, channel 5.
	assign ch5_hold = clock_control5_ff[`PWG_CH5_CLR_BIT];

	pwg_counter u_cnt0 (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.slow_tick (slow_tick),
		.fast_tick (fast_tick),
		.clk_sel   (clock_control_ff[`PWG_CH0_CKS_BIT]),
		.psc       (clock_control_ff[`PWG_PSC_HI:`PWG_PSC_LO]),
		.period    (ch0_period_ff),
		.hold      (1'b0),
		.count_ff  (cnt0),
		.wrap_ff   ()
	);

	pwg_counter u_cnt14 (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.slow_tick (slow_tick),
		.fast_tick (fast_tick),
		.clk_sel   (clock_control_ff[`PWG_CH14_CKS_BIT]),
		.psc       (clock_control_ff[`PWG_CH14_PSC_HI:`PWG_CH14_PSC_LO]),
		.period    (ch1_to_4_period_ff),
		.hold      (1'b0),
		.count_ff  (cnt14),
		.wrap_ff   ()
	);

	pwg_counter u_cnt5 (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.slow_tick (slow_tick),
		.fast_tick (fast_tick),
		.clk_sel   (clock_control5_ff[`PWG_CH5_CKS_BIT]),
		.psc       (clock_control5_ff[`PWG_PSC_HI:`PWG_PSC_LO]),
		.period    (ch5_period_ff),
		.hold      (ch5_hold),
		.count_ff  (cnt5),
		.wrap_ff   (wrap5)
	);

	// Each channel is active while its count is below its duty.
	generate
		for (gi = 0; gi < 6; gi = gi + 1) begin : g_wave
			logic [7:0] cnt_sel;
			assign cnt_sel = (gi == 0) ? cnt0 : (gi == 5) ? cnt5 : cnt14;
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					wave_ff[gi] <= 1'b0;
				end else begin
					wave_ff[gi] <= cnt_sel < duty_ff[gi];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Pin routing; the negative pin of channel 0 is the complement.
	assign wave_pins = {wave_ff[5], wave_ff[4], wave_ff[4], wave_ff[3],
		wave_ff[2], wave_ff[1], wave_ff[0], !wave_ff[0]};

	// A disabled pin is released and its data held low.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_ff <= 8'h00;
		end else begin
			pin_ff <= wave_pins & pin_enables_ff;
		end
	end

	assign pwm_pin_out  = pin_ff;
	assign pwm_pin_oe_n = ~pin_enables_ff;

	// Drive strength selects go straight to the pad drivers.
	assign ch0_pump_drive_select = clock_control5_ff[`PWG_PUMP_BIT];
	assign ch1_high_sink_select  = clock_control5_ff[`PWG_SINK_BIT];

	////////////////////////////////////////////////////////////////////
	// Checks.
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	sequence s_wr_answer;
		s_axi_bvalid;
	endsequence

	a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		s_wr_taken |=> s_wr_answer)
		else $error("Write response not one cycle after the take.");

	a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
		else $error("Read answer not one cycle after the take.");

	a_flag_sets: assert property (@(posedge aclk) disable iff (!aresetn)
		wrap5 |=> ch5_period_full_flag_ff && ch5_irq && ch5_wake)
		else $error("Period full did not raise the flag.");

	a_flag_entry_clr: assert property (@(posedge aclk) disable iff (!aresetn)
		(isr_entry && !wrap5) |=> !ch5_period_full_flag_ff)
		else $error("Handler entry did not clear the flag.");

	a_neg_complement: assert property (@(posedge aclk) disable iff (!aresetn)
		(pin_enables_ff[1:0] == 2'h3) |=> (pwm_pin_out[1] != pwm_pin_out[0]))
		else $error("Channel 0 pair not complementary.");

	a_pin_gated: assert property (@(posedge aclk) disable iff (!aresetn)
		(pin_enables_ff == 8'h00) |=> (pwm_pin_out == 8'h00))
		else $error("Disabled pin was driven.");

	a_duty_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(duty_ff[3] == 8'h00) |=> !wave_ff[3])
		else $error("Zero duty produced active time.");

	a_hold_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
		ch5_hold [*2] |-> !wrap5 && (cnt5 == 8'h00))
		else $error("Held channel 5 counter moved.");

endmodule : pwg_top

// File: six_channel_pwm_generator_test.sv
// Self-checking bench for the waveform generator over AXI4-Lite.
// Assumes the fast tick runs every cycle and the slow tick every second.
`timescale 1ns/1ps
`include "pwg_params.svh"

module six_channel_pwm_generator_test;
	logic              aclk, aresetn, awvalid, wvalid, bready, arvalid;
	logic              rready, slow_tick, fast_tick, isr_entry, clr, meas;
	logic [11:0]       awaddr, araddr;
	logic [31:0]       wdata;
	logic [3:0]        wstrb;
	wire               awready, wready, bvalid, arready, rvalid;
	wire  [1:0]        bresp, rresp;
	wire  [31:0]       rdata;
	wire               irq, wake, pump, sink;
	wire  [7:0]        pins, oe_n;
	wire  [7:0][7:0]   hi;
	int                n_fail, checks_done, cyc, n;
	logic [9:0] ridx [13] = '{`PWG_IDX_INT_FLAGS, `PWG_IDX_CH0_PERIOD,
		`PWG_IDX_CH0_DUTY, `PWG_IDX_CH14_PERIOD, `PWG_IDX_CH1_DUTY,
		`PWG_IDX_CH2_DUTY, `PWG_IDX_CH3_DUTY, `PWG_IDX_CLK_CTRL,
		`PWG_IDX_CLK_CTRL5, `PWG_IDX_CH4_DUTY, `PWG_IDX_CH5_DUTY,
		`PWG_IDX_CH5_PERIOD, `PWG_IDX_PIN_ENABLES};
	logic [7:0] rrst [13] = '{8'h00, 8'hff, 8'h80, 8'hff, 8'h80, 8'h80,
		8'h80, 8'h00, 8'h40, 8'h80, 8'h80, 8'hff, 8'h00};
	// Config order matches ridx[1..12]: CE and CF sit at entries 7 and 8.
	logic [7:0] cval [13] = '{8'h00, 8'h03, 8'h01, 8'h01, 8'h01, 8'h02,
		8'h00, 8'h6f, 8'h3f, 8'h01, 8'h03, 8'h07, 8'hff};
	logic [7:0] hexp [8] = '{8'h90, 8'h30, 8'h60, 8'hc0, 8'h00, 8'h60,
		8'h60, 8'h48};

	pwg_top u_pwg_top (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.slow_tick(slow_tick), .fast_tick(fast_tick),
		.isr_entry(isr_entry), .ch5_irq(irq), .ch5_wake(wake),
		.ch0_pump_drive_select(pump), .ch1_high_sink_select(sink),
		.pwm_pin_out(pins), .pwm_pin_oe_n(oe_n));
	pwg_pin_load u_pwg_pin_load (.aclk(aclk), .pin_out(pins),
		.pin_oe_n(oe_n), .clr(clr), .meas(meas), .hi_cnt(hi));

	////////////////////////////////////////////////////////////////////////
	// One compare for every result; values are zero-extended to a word.
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Address and data go out together; bready waits up from the start.
	task wr(input logic [9:0] idx, input logic [7:0] d, input logic s,
		input logic [1:0] er);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h000000, d};
		wstrb <= {3'h0, s};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge aclk); while (!(awready && wready));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge aclk); while (bvalid !== 1'b1);
		chk({30'h0, bresp}, {30'h0, er});
	endtask : wr

	// Reads one register and compares its word and response. The ready
	// lines stay high between transfers so that back-to-back calls never
	// drop and raise them in the same time step.
	task rd(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		chk(rdata, {24'h000000, d});
		chk({30'h0, rresp}, {30'h0, er});
	endtask : rd

	// Bounded wait for the period-full interrupt.
	task wait_irq();
		n = 0;
		while (irq !== 1'b1 && n < 400) begin
			@(posedge aclk);
			n++;
		end
	endtask : wait_irq

	task end_of_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test

	////////////////////////////////////////////////////////////////////////
	// Clock of 4 ns, and a slow tick on every second edge.
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	always @(posedge aclk) slow_tick <= ~slow_tick;

	// A hung handshake must not stall the run forever.
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			end_of_test();
		end
	end

	// Main sequence.
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{slow_tick, isr_entry, clr, meas} = 4'h0;
		fast_tick = 1'b1;
		{awaddr, araddr, wdata, wstrb} = 60'h0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 13; i++) rd(ridx[i], rrst[i], `PWG_RESP_OKAY);
		chk({pins, oe_n, 6'h0, irq, wake}, 32'h00ff00);
		for (int i = 1; i < 13; i++) wr(ridx[i], 8'h5a, 1'b1, 2'h0);
		for (int i = 1; i < 13; i++) rd(ridx[i], 8'h5a, 2'h0);
		wr(10'h000, 8'h11, 1'b1, `PWG_RESP_SLVERR);
		rd(10'h000, 8'h00, `PWG_RESP_SLVERR);
		wr(`PWG_IDX_CH0_DUTY, 8'h33, 1'b0, `PWG_RESP_OKAY);
		rd(`PWG_IDX_CH0_DUTY, 8'h5a, `PWG_RESP_OKAY);
		// Channel 5: fast source, divide by 128, two count clocks a period.
		wr(`PWG_IDX_CH5_PERIOD, 8'h01, 1'b1, 2'h0);
		wr(`PWG_IDX_CLK_CTRL5, 8'h48, 1'b1, 2'h0);
		repeat (300) @(posedge aclk);
		chk({31'h0, irq}, 32'h0);
		wr(`PWG_IDX_CLK_CTRL5, 8'h08, 1'b1, 2'h0);
		wait_irq();
		chk({31'h0, n >= 250 && n <= 262}, 32'h1);
		chk({31'h0, wake}, 32'h1);
		rd(`PWG_IDX_INT_FLAGS, 8'h08, 2'h0);
		isr_entry <= 1'b1;
		@(posedge aclk);
		isr_entry <= 1'b0;
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 32'h0);
		wait_irq();
		chk({31'h0, irq}, 32'h1);
		wr(`PWG_IDX_INT_FLAGS, 8'hff, 1'b1, 2'h0);
		rd(`PWG_IDX_INT_FLAGS, 8'h08, 2'h0);
		wr(`PWG_IDX_INT_FLAGS, 8'hf7, 1'b1, 2'h0);
		rd(`PWG_IDX_INT_FLAGS, 8'h00, 2'h0);
		// All channels at once; 192 cycles spans whole periods of each.
		for (int i = 1; i < 13; i++) wr(ridx[i], cval[i], 1'b1, 2'h0);
		chk({pump, sink, oe_n}, 32'h300);
		repeat (20) @(posedge aclk);
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
		meas <= 1'b1;
		repeat (192) @(posedge aclk);
		meas <= 1'b0;
		@(posedge aclk);
		for (int i = 0; i < 8; i++) chk(hi[i], hexp[i]);
		wr(`PWG_IDX_PIN_ENABLES, 8'h00, 1'b1, 2'h0);
		repeat (3) @(posedge aclk);
		chk({pins, oe_n}, 32'h00ff);
		end_of_test();
	end
endmodule : six_channel_pwm_generator_test
